//--- src/esc_top.sv
/*
 Event status register (clear on read) and CRC result register, reached
 over a 32-bit serial frame framed by an active-low select.
// How it works
// RULE_01: Warning flag sets on both warning edges.
// RULE_02: Shutdown flag sets on both shutdown edges.
// RULE_03: Reading event status clears all bits.
// RULE_04: Any switch threshold crossing sets switch flag.
// RULE_05: First finished poll cycle sets switch flag.
// RULE_06: Even-ones frame discarded, parity flag set.
// RULE_07: Parity flag mirrored into response status.
// RULE_08: Only exactly 32 clocks latch a word.
// RULE_09: Wrong clock count sets frame-length flag.
// RULE_10: Frame-length flag mirrored into response status.
// RULE_11: Select without clocks raises no error.
// RULE_12: Reset flag resets to one.
// RULE_13: Any reset restores all registers, state.
// RULE_14: Reset flag mirrored into response status.
// RULE_15: CRC bits 15-0 result, 23-16 zero.
// RULE_16: CRC register at 3h, resets FFFFh.
// RULE_17: Host compares its own CRC.
// RULE_18: Finished CRC calculation sets done flag.
// RULE_19: Event in clearing cycle stays set.
 Assumes: the select, serial clock and data pins and the two temperature
 levels are asynchronous; the serial clock is far slower than clk (at
 least four clk periods per half period). Switch levels, CRC result and
 poll completion come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module esc_top
   import esc_pkg::*;
#(
   parameter int N_SWITCH = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   output var logic so,
   output var logic so_en_n,
   // Temperature monitors
   input wire logic temp_warning,
   input wire logic thermal_shutdown,
   // Switch monitor
   input wire logic [N_SWITCH-1:0] switch_state,
   input wire logic poll_cycle_done,
   output var logic poll_start,
   // CRC engine
   input wire logic crc_done,
   input wire logic [15:0] crc_value,
   output var logic crc_start
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic srst;
   logic next_srst;
   logic rst_n_all;
   logic cs_n_s;
   logic sclk_s;
   logic si_s;
   logic warn_s;
   logic shut_s;
   logic sclk_q;
   logic warn_q;
   logic shut_q;
   logic armed;
   logic sw_changed;
   logic sclk_rise;
   logic sclk_fall;
   esc_link_type state;
   esc_link_type next_state;
   logic [CNT_W-1:0] bit_cnt;
   logic [CNT_W-1:0] next_bit_cnt;
   logic [FRAME_BITS-1:0] rx_sh;
   logic [FRAME_BITS-1:0] next_rx_sh;
   logic [FRAME_BITS-1:0] tx_sh;
   logic [FRAME_BITS-1:0] next_tx_sh;
   logic [FRAME_BITS-1:0] resp;
   logic next_so;
   logic next_so_en_n;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] next_rd_data;
   logic [DATA_W-1:0] reg_read;
   logic [DATA_W-1:0] event_status;
   logic [DATA_W-1:0] next_event_status;
   logic [DATA_W-1:0] ev_set;
   logic [15:0] crc_result;
   logic [15:0] next_crc_result;
   logic poll_wait;
   logic next_poll_wait;
   logic next_poll_start;
   logic next_crc_start;
   logic frame_err;
   logic parity_err;
   logic word_ok;
   logic is_write;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic clear_event;
   logic wr_ctrl;

   initial begin
      if (N_SWITCH < 1 || N_SWITCH > 24) $error("esc_top: N_SWITCH must be 1 to 24");
   end

   // Soft reset acts like the pin reset one cycle after the write
   assign rst_n_all = nrst & ~srst; // RULE_13

   // ------------------------------------------------------------
   // Input synchronisers and edge finding
   // ------------------------------------------------------------
   // Select idles high, so its stages reset high and no frame is faked after reset
   esc_sync #(
      .W(5),
      .RST(5'h10)
   ) u_sync (
      .clk(clk),
      .nrst(rst_n_all),
      .d({cs_n, sclk, si, temp_warning, thermal_shutdown}),
      .q({cs_n_s, sclk_s, si_s, warn_s, shut_s})
   );

   esc_change #(
      .W(N_SWITCH)
   ) u_change (
      .clk(clk),
      .nrst(rst_n_all),
      .d(switch_state),
      .changed(sw_changed)
   );

   assign sclk_rise = sclk_s & ~sclk_q;
   assign sclk_fall = ~sclk_s & sclk_q;

   always_ff @(posedge clk) begin
      if (!rst_n_all) begin
         sclk_q <= 1'b0;
         warn_q <= 1'b0;
         shut_q <= 1'b0;
         armed <= 1'b0;
      end else begin
         sclk_q <= sclk_s;
         warn_q <= warn_s;
         shut_q <= shut_s;
         armed <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Frame decode
   // ------------------------------------------------------------
   assign is_write = rx_sh[FR_RW];
   assign addr = rx_sh[FR_ADDR_LO +: ADDR_W];
   assign wdata = rx_sh[FR_DATA_LO +: DATA_W];

   // Word is taken only on exactly 32 clocks and odd ones count
   always_comb begin
      word_ok = 1'b0;
      frame_err = 1'b0;
      parity_err = 1'b0;
      if (state == LK_EVAL) begin
         if (bit_cnt == CNT_W'(FRAME_BITS)) begin // RULE_08
            if (^rx_sh) begin
               word_ok = 1'b1;
            end else begin
               parity_err = 1'b1; // RULE_06
            end
         end else if (bit_cnt != '0) begin // RULE_11
            frame_err = 1'b1; // RULE_09
         end
      end
   end

   assign clear_event = word_ok && !is_write && (addr == OFS_EVENT); // RULE_03
   assign wr_ctrl = word_ok && is_write && (addr == OFS_CTRL);

   always_comb begin
      case (addr)
         OFS_EVENT: reg_read = event_status;
         OFS_CRC: reg_read = {8'h00, crc_result}; // RULE_15
         default: reg_read = '0;
      endcase
   end

   // ------------------------------------------------------------
   // Link state machine and shifters
   // ------------------------------------------------------------
   // Response carries status plus the data of the previous read
   always_comb begin
      resp = '0;
      resp[RS_RESET] = event_status[EV_POR]; // RULE_14
      resp[RS_FRAME] = event_status[EV_FRAME]; // RULE_10
      resp[RS_PARITY] = event_status[EV_PARITY]; // RULE_07
      resp[RS_DATA_LO +: DATA_W] = rd_data;
      resp[0] = ~^resp[FRAME_BITS-1:1];
   end

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_rx_sh = rx_sh;
      next_tx_sh = tx_sh;
      next_so = so;
      next_so_en_n = so_en_n;
      next_rd_data = rd_data;
      case (state)
         LK_IDLE: begin
            next_so_en_n = 1'b1;
            if (!cs_n_s) begin
               next_state = LK_SHIFT;
               next_bit_cnt = '0;
               next_tx_sh = resp;
               next_so = resp[FRAME_BITS-1];
               next_so_en_n = 1'b0;
            end
         end
         LK_SHIFT: begin
            if (cs_n_s) begin
               next_state = LK_EVAL;
               next_so_en_n = 1'b1;
            end else begin
               if (sclk_rise) begin
                  next_rx_sh = {rx_sh[FRAME_BITS-2:0], si_s};
                  // Saturate at 63 so long frames never wrap to a legal count
                  if (bit_cnt != '1) begin
                     next_bit_cnt = bit_cnt + CNT_W'(1); // RULE_08
                  end
               end
               if (sclk_fall) begin
                  next_tx_sh = {tx_sh[FRAME_BITS-2:0], 1'b0};
                  next_so = tx_sh[FRAME_BITS-2];
               end
            end
         end
         LK_EVAL: begin
            next_state = LK_IDLE;
            if (word_ok && !is_write) begin
               next_rd_data = reg_read;
            end
         end
         default: begin
            next_state = LK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n_all) begin
         state <= LK_IDLE; // RULE_13
         bit_cnt <= '0;
         rx_sh <= '0;
         tx_sh <= '0;
         so <= 1'b0;
         so_en_n <= 1'b1;
         rd_data <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         rx_sh <= next_rx_sh;
         tx_sh <= next_tx_sh;
         so <= next_so;
         so_en_n <= next_so_en_n;
         rd_data <= next_rd_data;
      end
   end

   // ------------------------------------------------------------
   // Event status, CRC result and control
   // ------------------------------------------------------------
   always_comb begin
      ev_set = '0;
      ev_set[EV_WARNING] = armed && (warn_s ^ warn_q); // RULE_01
      ev_set[EV_SHUTDOWN] = armed && (shut_s ^ shut_q); // RULE_02
      ev_set[EV_SWITCH] = sw_changed | (poll_wait & poll_cycle_done); // RULE_04 RULE_05
      ev_set[EV_PARITY] = parity_err; // RULE_06
      ev_set[EV_FRAME] = frame_err; // RULE_09
      ev_set[EV_CRC] = crc_done; // RULE_18
   end

   // Set wins over the read clear so nothing is lost
   always_comb begin
      next_event_status = (clear_event ? '0 : event_status) | ev_set; // RULE_03 RULE_19
      next_crc_result = crc_done ? crc_value : crc_result; // RULE_18
      next_poll_wait = poll_wait;
      if (poll_cycle_done) begin
         next_poll_wait = 1'b0; // RULE_05
      end
      if (wr_ctrl && wdata[CTL_POLL]) begin
         next_poll_wait = 1'b1;
      end
      next_poll_start = wr_ctrl && wdata[CTL_POLL];
      next_crc_start = wr_ctrl && wdata[CTL_CRC];
      next_srst = wr_ctrl && wdata[CTL_SRST];
   end

   always_ff @(posedge clk) begin
      if (!rst_n_all) begin
         event_status <= EVENT_RESET; // RULE_12
         crc_result <= CRC_RESET; // RULE_16
         poll_wait <= 1'b0;
         poll_start <= 1'b0;
         crc_start <= 1'b0;
      end else begin
         event_status <= next_event_status;
         crc_result <= next_crc_result;
         poll_wait <= next_poll_wait;
         poll_start <= next_poll_start;
         crc_start <= next_crc_start;
      end
   end

   // The soft reset request only answers to the pin reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         srst <= 1'b0;
      end else begin
         srst <= next_srst; // RULE_12
      end
   end
endmodule
`default_nettype wire

//--- src/esc_pkg.sv
/*
 Constants shared by the event status and CRC readback block: frame layout,
 register offsets, event bit positions and reset values.
 Assumes a 32-bit full-duplex serial frame framed by an active-low select.
*/
package esc_pkg;
   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int FRAME_BITS = 32;
   localparam int CNT_W = 6;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam int FR_RW = 31;
   localparam int FR_ADDR_LO = 25;
   localparam int FR_DATA_LO = 1;
   localparam int RS_RESET = 31;
   localparam int RS_FRAME = 30;
   localparam int RS_PARITY = 29;
   localparam int RS_DATA_LO = 1;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [5:0] OFS_EVENT = 6'h02;
   localparam logic [5:0] OFS_CRC = 6'h03;
   localparam logic [5:0] OFS_CTRL = 6'h1a;
   localparam int EV_POR = 0;
   localparam int EV_FRAME = 1;
   localparam int EV_PARITY = 2;
   localparam int EV_SWITCH = 3;
   localparam int EV_SHUTDOWN = 4;
   localparam int EV_WARNING = 5;
   localparam int EV_CRC = 8;
   localparam logic [23:0] EVENT_RESET = 24'h000001;
   localparam logic [15:0] CRC_RESET = 16'hffff;
   localparam int CTL_SRST = 0;
   localparam int CTL_POLL = 1;
   localparam int CTL_CRC = 2;

   typedef enum logic [1:0] {LK_IDLE, LK_SHIFT, LK_EVAL} esc_link_type;
endpackage

//--- src/esc_sync.sv
/*
 Two-stage synchroniser for a group of asynchronous levels.
 Assumes a synchronous active-low reset in the receiving domain.
*/
`timescale 1ns/1ps
`default_nettype none
module esc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Levels
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   initial begin
      if (W < 1) $error("esc_sync: width must be at least one");
   end

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta <= RST;
         q <= RST;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule
`default_nettype wire

//--- src/esc_change.sv
/*
 Per-bit change detector: one pulse whenever any input bit differs from
 the value it held the cycle before. Inputs are in the clock's domain.
*/
`timescale 1ns/1ps
`default_nettype none
module esc_change #(
   parameter int W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Levels in, change pulse out
   input wire logic [W-1:0] d,
   output var logic changed
);
   logic [W-1:0] prev;
   logic [W-1:0] diff;
   logic armed;
   logic next_changed;

   initial begin
      if (W < 1) $error("esc_change: width must be at least one");
   end

   // One comparator per input
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign diff[i] = d[i] ^ prev[i];
      end
   endgenerate

   // The first sample after reset only arms, so the reset value fakes nothing
   always_comb begin
      next_changed = armed && (|diff);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prev <= '0;
         armed <= 1'b0;
         changed <= 1'b0;
      end else begin
         prev <= d;
         armed <= 1'b1;
         changed <= next_changed;
      end
   end
endmodule
`default_nettype wire

//--- verification/esc_top_checker.sv
/*
 Port-level checks on the event status and CRC readback block.
 Assumes it is bound to esc_top and sees only the ports of that module.
*/
`timescale 1ns/1ps
`default_nettype none
module esc_top_checker
   import esc_pkg::*;
#(
   parameter int N_SWITCH = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic so,
   input wire logic so_en_n,
   // Monitors and engines
   input wire logic temp_warning,
   input wire logic thermal_shutdown,
   input wire logic [N_SWITCH-1:0] switch_state,
   input wire logic poll_cycle_done,
   input wire logic poll_start,
   input wire logic crc_done,
   input wire logic [15:0] crc_value,
   input wire logic crc_start
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence frame_open;
      $fell(cs_n) ##1 (!cs_n) [*5];
   endsequence
   // Six quiet cycles leave room for the two-stage sampling of the serial clock
   sequence link_quiet;
      (!cs_n && $stable(sclk)) [*6];
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   reset_idle_a: assert property (
      disable iff (1'b0) !nrst |=> so_en_n && !poll_start && !crc_start)
      else $error("outputs not idle after reset");
   enable_off_a: assert property (cs_n [*5] |-> so_en_n)
      else $error("data out still enabled between frames");
   enable_on_a: assert property (frame_open |-> !so_en_n)
      else $error("data out not enabled during a frame");
   enable_cause_a: assert property (
      $fell(so_en_n) |-> !$past(cs_n) && !$past(cs_n, 2))
      else $error("data out enabled without a select");
   so_hold_a: assert property (link_quiet |-> $stable(so))
      else $error("data out moved without a serial clock edge");
   poll_pulse_a: assert property (poll_start |=> !poll_start)
      else $error("poll trigger longer than one cycle");
   crc_pulse_a: assert property (crc_start |=> !crc_start)
      else $error("crc trigger longer than one cycle");
   start_cause_a: assert property (
      poll_start || crc_start |-> $past(cs_n) && $past(cs_n, 2))
      else $error("trigger issued while a frame was open");
endmodule
bind esc_top esc_top_checker #(.N_SWITCH(N_SWITCH)) esc_top_checker_i (.clk(clk), .nrst(nrst),
   .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_en_n(so_en_n), .temp_warning(temp_warning),
   .thermal_shutdown(thermal_shutdown), .switch_state(switch_state),
   .poll_cycle_done(poll_cycle_done), .poll_start(poll_start), .crc_done(crc_done),
   .crc_value(crc_value), .crc_start(crc_start));
`default_nettype wire

//--- verification/esc_host.sv
/*
 Host controller model: sends one word per select-low period and collects the reply.
 Assumes the caller spaces frames; serial clock half period is 200 ns, idle low.
*/
`timescale 1ns/1ps
`default_nettype none
module esc_host (
   // Link pins towards the device
   output var logic cs_n,
   output var logic sclk,
   output var logic si,
   input wire logic so,
   input wire logic so_en_n
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // A disabled data out line is read as unknown so a stray bit never matches
   task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
      r = 32'h0;
      cs_n = 1'b0;
      #400;
      for (int i = 0; i < n; i++) begin
         si = w[31 - (i % 32)];
         #200 sclk = 1'b1;
         r = {r[30:0], so_en_n ? 1'bx : so};
         #200 sclk = 1'b0;
      end
      #200 cs_n = 1'b1;
      si = ~si;
      #600;
   endtask
endmodule
`default_nettype wire

//--- verification/esc_top_bench.sv
/*
 Self-checking bench: the host model sends frames, the bench predicts replies.
 Assumes esc_pkg, esc_top, esc_host and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module esc_top_bench
   import esc_pkg::*;
;
   logic clk, nrst, cs_n, sclk, si, so, so_en_n, warn, shut, pdone, pgo, cdone, cgo;
   logic [23:0] sw, ev, pend;
   logic [15:0] cval, crc;
   int mismatches = 0, compares = 0, seed = 95, polls = 0, crcs = 0, pick;
   esc_top #(.N_SWITCH(24)) esc_top_i (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
      .si(si), .so(so), .so_en_n(so_en_n), .temp_warning(warn), .thermal_shutdown(shut),
      .switch_state(sw), .poll_cycle_done(pdone), .poll_start(pgo), .crc_done(cdone),
      .crc_value(cval), .crc_start(cgo));
   esc_host esc_host_i (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_en_n(so_en_n));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pgo === 1'b1) polls++;
      if (cgo === 1'b1) crcs++;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic conclude();
      if (mismatches == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] mk(input logic rw, input logic [5:0] a, input logic [23:0] d);
      return {rw, a, d, ~^{rw, a, d}};
   endfunction
   // Reply data belongs to the previous valid read, so pend carries it over
   task automatic frame(input logic [31:0] w, input int n);
      logic [31:0] r;
      logic [31:0] x;
      logic [31:0] e;
      x = {ev[EV_POR], ev[EV_FRAME], ev[EV_PARITY], 4'h0, pend, 1'b0};
      x[0] = ~^x[31:1];
      e = 32'h0;
      // The host keeps the last 32 bits; past the word the line shifts zeros
      for (int i = 0; i < n; i++) begin
         e = {e[30:0], (i < FRAME_BITS) ? x[31 - (i % 32)] : 1'b0};
      end
      esc_host_i.xfer(w, n, r);
      if (n == 0) return;
      chk(r, e);
      if (n != FRAME_BITS) ev[EV_FRAME] = 1'b1;
      else if (!(^w)) ev[EV_PARITY] = 1'b1;
      else if (!w[FR_RW]) begin
         pend = (w[30:25] == OFS_EVENT) ? ev : (w[30:25] == OFS_CRC) ? {8'h0, crc} : 24'h0;
         if (w[30:25] == OFS_EVENT) ev = 24'h0;
      end else if (w[30:25] == OFS_CTRL && w[FR_DATA_LO + CTL_SRST]) begin
         ev = EVENT_RESET;
         crc = CRC_RESET;
         pend = 24'h0;
      end
   endtask
   task automatic hw_reset();
      @(negedge clk);
      nrst = 1'b0;
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      ev = EVENT_RESET;
      crc = CRC_RESET;
      pend = 24'h0;
   endtask
   task automatic ev_step(input int k);
      @(negedge clk);
      case (k)
         0: begin warn = ~warn; ev[EV_WARNING] = 1'b1; end
         1: begin shut = ~shut; ev[EV_SHUTDOWN] = 1'b1; end
         default: begin
            pick = $random(seed);
            ev[EV_SWITCH] = ev[EV_SWITCH] | (sw != pick[23:0]);
            sw = pick[23:0];
         end
      endcase
      repeat (8) @(negedge clk);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      #3000000;
      mismatches++;
      conclude();
   end
   initial begin
      nrst = 1'b0;
      warn = 1'b0;
      shut = 1'b0;
      sw = 24'h0;
      pdone = 1'b0;
      cdone = 1'b0;
      cval = 16'h0;
      hw_reset();
      frame(mk(1'b0, OFS_CRC, 24'h0), 32);
      frame(mk(1'b0, OFS_EVENT, 24'h0), 32);
      frame(mk(1'b0, OFS_EVENT, 24'h0), 31);
      frame(mk(1'b0, OFS_EVENT, 24'h0), 33);
      frame(32'h0, 0);
      frame(mk(1'b1, OFS_CTRL, 24'h1) ^ 32'h1, 32);
      frame(mk(1'b1, OFS_EVENT, 24'($random(seed))), 32);
      frame(mk(1'b1, OFS_CRC, 24'($random(seed))), 32);
      frame(mk(1'b0, OFS_EVENT, 24'h0), 32);
      frame(mk(1'b0, OFS_CRC, 24'h0), 32);
      frame(mk(1'b1, OFS_CTRL, 24'h1), 32);
      frame(mk(1'b1, OFS_CTRL, 24'h2), 32);
      chk(polls, 1);
      @(negedge clk) pdone = 1'b1;
      @(negedge clk) pdone = 1'b0;
      ev[EV_SWITCH] = 1'b1;
      frame(mk(1'b0, OFS_EVENT, 24'h0), 32);
      @(negedge clk) pdone = 1'b1;
      @(negedge clk) pdone = 1'b0;
      frame(mk(1'b1, OFS_CTRL, 24'h4), 32);
      chk(crcs, 1);
      @(negedge clk);
      cval = 16'($random(seed));
      cdone = 1'b1;
      @(negedge clk) cdone = 1'b0;
      crc = cval;
      cval = ~cval;
      ev[EV_CRC] = 1'b1;
      frame(mk(1'b0, OFS_CRC, 24'h0), 32);
      frame(mk(1'b0, OFS_EVENT, 24'h0), 32);
      // Each level goes up then down so both edges must raise the flag
      for (int i = 0; i < 4; i++) begin
         ev_step(i / 2);
         frame(mk(1'b0, OFS_EVENT, 24'h0), 32);
      end
      for (int i = 0; i < 12; i++) begin
         ev_step({$random(seed)} % 3);
         frame(mk(1'b0, ({$random(seed)} % 2) ? OFS_EVENT : OFS_CRC, 24'h0), 32);
      end
      @(negedge clk);
      warn = 1'b0;
      shut = 1'b0;
      sw = 24'h0;
      repeat (8) @(negedge clk);
      hw_reset();
      frame(mk(1'b0, OFS_CRC, 24'h0), 32);
      frame(mk(1'b0, OFS_EVENT, 24'h0), 32);
      frame(mk(1'b0, OFS_CRC, 24'h0), 32);
      conclude();
   end
endmodule
`default_nettype wire
